// ---- rtl/pllctl_pkg.sv ----
package pllctl_pkg;

	localparam int NUM_OUT = 4;
	localparam int ADDR_W  = 5;
	localparam int DATA_W  = 8;
	localparam int CNT_W   = 9;
	localparam int LOCK_W  = 16;

	// ****************************************
	// settings map
	// ****************************************
	localparam logic [4:0] REG_DIV_BASE   = 5'h00;
	localparam logic [4:0] REG_MDIV       = 5'h04;
	localparam logic [4:0] REG_PHASE_BASE = 5'h05;
	localparam logic [4:0] REG_CTRL       = 5'h09;
	localparam logic [4:0] REG_STATUS     = 5'h0A;

	localparam int CTRL_PHASE_SRC_BIT = 0;
	localparam int STAT_LOCK_BIT      = 0;
	localparam int STAT_STANDBY_REQUEST_BIT     = 1;

	localparam logic [7:0] DIV_RST   = 8'h03;
	localparam logic [7:0] MDIV_RST  = 8'h01;
	localparam logic [7:0] PHASE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST  = 8'h00;

	localparam logic [1:0] FEEDBACK_OUT = 2'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_FREQ_KHZ = 10000;
	localparam int LOCK_TIME_US = 15;
	localparam int LOCK_CYCLES_I = (LOCK_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
	localparam logic [15:0] LOCK_CYCLES = LOCK_CYCLES_I[15:0];

	typedef struct packed {
		logic [31:0][7:0]             settings;
		logic [NUM_OUT-1:0][7:0]      port_phase;
		logic [NUM_OUT-1:0][CNT_W-1:0] div_cnt;
		logic [NUM_OUT-1:0]           out_clk;
		logic [7:0]                   mdiv_cnt;
		logic                         ref_seen;
		logic [LOCK_W-1:0]            lock_cnt;
		logic                         locked;
		logic                         ref_a_q;
		logic                         ref_b_q;
		logic                         ref_sel_q;
		logic                         fb_q;
		logic                         step_q;
		logic                         bclk_q;
		logic                         ack;
		logic                         done;
		logic [7:0]                   rdata;
	} pllctl_state_s;

endpackage

// ---- rtl/pllctl_top.sv ----
`timescale 1ns/1ps
module pllctl_top (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    ref_clk_in_a,
	input  wire logic                    ref_clk_in_b,
	input  wire logic                    ref_select,
	input  wire logic                    feedback_clk_in,
	input  wire logic [1:0]              phase_output_select,
	input  wire logic                    phase_direction,
	input  wire logic                    phase_step_toggle,
	input  wire logic                    standby_request,
	input  wire logic                    pll_reset,
	input  wire logic                    full_reset_with_input_divider,
	input  wire logic                    out_b_divider_reset,
	input  wire logic                    out_c_divider_reset,
	input  wire logic                    primary_out_enable,
	input  wire logic                    secondary_a_out_enable,
	input  wire logic                    secondary_b_out_enable,
	input  wire logic                    secondary_c_out_enable,
	input  wire logic                    settings_bus_clk,
	input  wire logic                    settings_bus_reset,
	input  wire logic                    settings_bus_strobe,
	input  wire logic                    settings_bus_write_enable,
	input  wire logic [pllctl_pkg::ADDR_W-1:0] settings_bus_addr,
	input  wire logic [pllctl_pkg::DATA_W-1:0] settings_bus_wdata,
	output logic      [pllctl_pkg::DATA_W-1:0] settings_bus_rdata,
	output logic                         settings_bus_ack,
	output logic                         primary_out_clk,
	output logic                         secondary_out_clk_a,
	output logic                         secondary_out_clk_b,
	output logic                         secondary_out_clk_c,
	output logic                         lock_indicator,
	output logic                         phase_source_status
);
	import pllctl_pkg::*;

	pllctl_state_s q_r;
	pllctl_state_s q_nxt;

	logic [NUM_OUT-1:0] en_w;
	assign en_w = {secondary_c_out_enable, secondary_b_out_enable,
		secondary_a_out_enable, primary_out_enable};

	// ****************************************
	// helpers
	// ****************************************
	// period of output i is 2*(div+1) clock cycles
	function automatic logic [CNT_W-1:0] last_cnt(input logic [7:0] div);
		last_cnt = {div, 1'b1};
	endfunction

	// phase preload, zeroed if past the period so a big value cannot stall the counter
	function automatic logic [CNT_W-1:0] preload(input logic [7:0] ph, input logic [7:0] div);
		logic [CNT_W-1:0] p;
		p = {1'b0, ph};
		preload = (p > last_cnt(div)) ? '0 : p;
	endfunction

	// free-running count, wraps at the end of the period
	function automatic logic [CNT_W-1:0] count_on(
		input logic [CNT_W-1:0] cnt,
		input logic [7:0]       div
	);
		if (cnt >= last_cnt(div)) begin
			count_on = '0;
		end else begin
			count_on = cnt + 9'h001;
		end
	endfunction

	// one extra count; wraps inside the period so a step never skips two phases
	function automatic logic [CNT_W-1:0] step_fwd(
		input logic [CNT_W-1:0] cnt,
		input logic [7:0]       div
	);
		logic [CNT_W-1:0] wrap_at;
		wrap_at = last_cnt(div);
		if (cnt >= wrap_at) begin
			step_fwd = 9'h001;
		end else if (cnt == wrap_at - 9'h001) begin
			step_fwd = '0;
		end else begin
			step_fwd = cnt + 9'h002;
		end
	endfunction

	// counters held in preload: loop reset holds all, the extra resets one each
	function automatic logic [NUM_OUT-1:0] held_outputs(
		input logic loop_rst,
		input logic rst_b,
		input logic rst_c
	);
		held_outputs = '0;
		for (int i = 0; i < NUM_OUT; i++) begin
			case (i)
				2:       held_outputs[i] = loop_rst | rst_b;
				3:       held_outputs[i] = loop_rst | rst_c;
				default: held_outputs[i] = loop_rst;
			endcase
		end
	endfunction

	// reads past the status byte return zero
	function automatic logic [7:0] read_word(
		input logic [31:0][7:0] regs,
		input logic [4:0]       addr,
		input logic [7:0]       stat
	);
		if (addr < REG_STATUS) begin
			read_word = regs[addr];
		end else if (addr == REG_STATUS) begin
			read_word = stat;
		end else begin
			read_word = 8'h00;
		end
	endfunction

	// status byte: lock in bit 0, standby in bit 1, the rest zero
	function automatic logic [7:0] status_word(
		input logic locked,
		input logic standby
	);
		status_word                 = 8'h00;
		status_word[STAT_LOCK_BIT]  = locked;
		status_word[STAT_STANDBY_REQUEST_BIT] = standby;
	endfunction

	// defaults: dividers at their reset value, phases and control cleared
	function automatic pllctl_state_s reset_state();
		pllctl_state_s s;
		s = '0;
		for (int i = 0; i < NUM_OUT; i++) begin
			s.settings[REG_DIV_BASE + 5'(i)]   = DIV_RST;
			s.settings[REG_PHASE_BASE + 5'(i)] = PHASE_RST;
			s.port_phase[i]                    = PHASE_RST;
		end
		s.settings[REG_MDIV] = MDIV_RST;
		s.settings[REG_CTRL] = CTRL_RST;
		reset_state = s;
	endfunction

	always_comb begin
		logic ref_now;
		logic ref_prev;
		logic ref_rise;
		logic fb_rise;
		logic step_edge;
		logic bclk_rise;
		logic bus_src;
		logic loop_rst;
		logic lose_lock;
		logic reload;
		logic [7:0] div;
		logic [7:0] ph;
		logic [7:0] stat;
		logic [NUM_OUT-1:0] hold;
		ref_now   = 1'b0;
		ref_prev  = 1'b0;
		ref_rise  = 1'b0;
		fb_rise   = 1'b0;
		step_edge = 1'b0;
		bclk_rise = 1'b0;
		bus_src   = 1'b0;
		loop_rst  = 1'b0;
		lose_lock = 1'b0;
		reload    = 1'b0;
		div       = 8'h00;
		ph        = 8'h00;
		stat      = 8'h00;
		hold      = '0;
		q_nxt = q_r;

		// ****************************************
		// input sampling and edges
		// ****************************************
		ref_now  = ref_select ? ref_clk_in_b : ref_clk_in_a;
		ref_prev = ref_select ? q_r.ref_b_q : q_r.ref_a_q;
		ref_rise = ref_now & ~ref_prev;
		fb_rise  = feedback_clk_in & ~q_r.fb_q;
		step_edge = phase_step_toggle ^ q_r.step_q;
		bclk_rise = settings_bus_clk & ~q_r.bclk_q;
		q_nxt.ref_a_q   = ref_clk_in_a;
		q_nxt.ref_b_q   = ref_clk_in_b;
		q_nxt.ref_sel_q = ref_select;
		q_nxt.fb_q      = feedback_clk_in;
		q_nxt.step_q    = phase_step_toggle;
		q_nxt.bclk_q    = settings_bus_clk;
		bus_src = q_r.settings[REG_CTRL][CTRL_PHASE_SRC_BIT];

		// ****************************************
		// settings bus
		// ****************************************
		stat = status_word(q_r.locked, standby_request);
		if (bclk_rise) begin
			if (settings_bus_reset) begin
				q_nxt.ack   = 1'b0;
				q_nxt.done  = 1'b0;
				q_nxt.rdata = 8'h00;
			end else if (q_r.ack) begin
				q_nxt.ack = 1'b0;
			end else if (settings_bus_strobe && !q_r.done) begin
				q_nxt.ack  = 1'b1;
				q_nxt.done = 1'b1;
				q_nxt.rdata = read_word(q_r.settings, settings_bus_addr, stat);
				// status and unmapped addresses drop writes but still answer
				if (settings_bus_write_enable && settings_bus_addr < REG_STATUS) begin
					q_nxt.settings[settings_bus_addr] = settings_bus_wdata;
					reload = 1'b1;
				end
			end else if (!settings_bus_strobe) begin
				q_nxt.done = 1'b0;
			end
		end

		// ****************************************
		// dividers and phase
		// ****************************************
		for (int i = 0; i < NUM_OUT; i++) begin
			div = q_r.settings[REG_DIV_BASE + 5'(i)];
			q_nxt.div_cnt[i] = count_on(q_r.div_cnt[i], div);
		end

		// port stepping slips the counter by one cycle either way
		if (step_edge && !bus_src) begin
			div = q_r.settings[REG_DIV_BASE + 5'(phase_output_select)];
			if (phase_direction) begin
				q_nxt.port_phase[phase_output_select] = q_r.port_phase[phase_output_select]
					+ 8'h01;
				q_nxt.div_cnt[phase_output_select] = step_fwd(
					q_r.div_cnt[phase_output_select], div);
			end else begin
				q_nxt.port_phase[phase_output_select] = q_r.port_phase[phase_output_select]
					- 8'h01;
				q_nxt.div_cnt[phase_output_select] = q_r.div_cnt[phase_output_select];
			end
			if (phase_output_select == FEEDBACK_OUT) begin
				lose_lock = 1'b1;
			end
		end

		// ****************************************
		// resets and lock
		// ****************************************
		loop_rst = pll_reset | full_reset_with_input_divider | standby_request;
		if (ref_select != q_r.ref_sel_q) begin
			lose_lock = 1'b1;
			q_nxt.ref_seen = 1'b0;
		end

		if (ref_rise) begin
			if (q_r.mdiv_cnt >= q_r.settings[REG_MDIV]) begin
				q_nxt.mdiv_cnt = 8'h00;
				q_nxt.ref_seen = 1'b1;
			end else begin
				q_nxt.mdiv_cnt = q_r.mdiv_cnt + 8'h01;
			end
		end

		// the feedback output's counter follows the feedback edge until lock is reached
		if (fb_rise && !q_r.locked && q_r.ref_seen) begin
			ph = bus_src ? q_r.settings[REG_PHASE_BASE + 5'(FEEDBACK_OUT)]
				: q_r.port_phase[FEEDBACK_OUT];
			q_nxt.div_cnt[FEEDBACK_OUT] = preload(ph,
				q_r.settings[REG_DIV_BASE + 5'(FEEDBACK_OUT)]);
		end

		if (q_r.ref_seen && !q_r.locked) begin
			if (q_r.lock_cnt >= LOCK_CYCLES - 16'h0001) begin
				q_nxt.locked = 1'b1;
			end else begin
				q_nxt.lock_cnt = q_r.lock_cnt + 16'h0001;
			end
		end

		hold = held_outputs(loop_rst, out_b_divider_reset, out_c_divider_reset);
		for (int i = 0; i < NUM_OUT; i++) begin
			div = q_r.settings[REG_DIV_BASE + 5'(i)];
			ph  = bus_src ? q_r.settings[REG_PHASE_BASE + 5'(i)] : q_r.port_phase[i];
			if (reload || hold[i]) begin
				q_nxt.div_cnt[i] = preload(ph, div);
			end
			// a held counter keeps its output low so the restart begins on a clean edge
			q_nxt.out_clk[i] = en_w[i] && !standby_request && !hold[i]
				&& (q_nxt.div_cnt[i] <= {1'b0, div});
		end

		if (reload || lose_lock || loop_rst) begin
			q_nxt.locked   = 1'b0;
			q_nxt.lock_cnt = '0;
		end
		if (loop_rst) begin
			q_nxt.ref_seen = 1'b0;
		end
		if (full_reset_with_input_divider) begin
			q_nxt.mdiv_cnt = 8'h00;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q_r <= reset_state();
		end else begin
			q_r <= q_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign settings_bus_rdata  = q_r.rdata;
	assign settings_bus_ack    = q_r.ack;
	assign primary_out_clk     = q_r.out_clk[0];
	assign secondary_out_clk_a = q_r.out_clk[1];
	assign secondary_out_clk_b = q_r.out_clk[2];
	assign secondary_out_clk_c = q_r.out_clk[3];
	// consumers must pass this through their own synchroniser
	assign lock_indicator      = q_r.locked;
	assign phase_source_status = q_r.settings[REG_CTRL][CTRL_PHASE_SRC_BIT];

endmodule

// ---- bench/pllctl_checker.sv ----
`timescale 1ns/1ps
module pllctl_checker
	import pllctl_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       settings_bus_clk,
	input wire logic       settings_bus_strobe,
	input wire logic       settings_bus_write_enable,
	input wire logic [4:0] settings_bus_addr,
	input wire logic       settings_bus_ack,
	input wire logic       lock_indicator,
	input wire logic       phase_source_status,
	input wire logic       standby_request,
	input wire logic       pll_reset,
	input wire logic       full_reset_with_input_divider,
	input wire logic       out_b_divider_reset,
	input wire logic       out_c_divider_reset,
	input wire logic       primary_out_enable,
	input wire logic       primary_out_clk,
	input wire logic       secondary_out_clk_b,
	input wire logic       secondary_out_clk_c
);
	// ********
	// properties
	// ********
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] low_r;
	logic [15:0] low_nxt;
	// saturates so a long unlock never wraps into a false pass
	always_comb low_nxt = lock_indicator ? 16'h0000 : low_r + {15'h0000, ~&low_r};
	always_ff @(posedge clock) low_r <= rst ? 16'h0000 : low_nxt;
	AST_ACK_RISE: assert property ($rose(settings_bus_ack) |->
		$past(settings_bus_strobe) && $past(settings_bus_clk) && !$past(settings_bus_clk, 2))
		else $error("ack without taken strobe");
	AST_ACK_FALL: assert property ($fell(settings_bus_ack) |->
		$past(settings_bus_clk) && !$past(settings_bus_clk, 2)) else $error("ack fell early");
	AST_WR_UNLOCK: assert property ($rose(settings_bus_ack) && $past(settings_bus_write_enable)
		&& $past(settings_bus_addr) < 5'h09 |-> !lock_indicator) else $error("lock kept");
	AST_LOCK_TIME: assert property ($rose(lock_indicator) |-> low_r >= LOCK_CYCLES)
		else $error("lock too soon");
	AST_STANDBY: assert property (standby_request |=> !lock_indicator
		&& !primary_out_clk && !secondary_out_clk_c) else $error("standby ignored");
	AST_LOOP_RST: assert property (pll_reset || full_reset_with_input_divider
		|=> !lock_indicator) else $error("loop reset ignored");
	AST_OUT_B: assert property (out_b_divider_reset |=> !secondary_out_clk_b)
		else $error("out b reset ignored");
	AST_OUT_C: assert property (out_c_divider_reset |=> !secondary_out_clk_c)
		else $error("out c reset ignored");
	AST_ENABLE: assert property (!primary_out_enable ##1 !primary_out_enable
		|=> !$rose(primary_out_clk)) else $error("disabled output rose");
	AST_SRC: assert property ($changed(phase_source_status) |->
		$rose(settings_bus_ack) || $past(rst)) else $error("source changed alone");
	cover property ($rose(lock_indicator));
	cover property ($rose(phase_source_status));
	cover property ($fell(lock_indicator) && !standby_request);
endmodule
bind pllctl_top pllctl_checker u_chk (.clock, .rst, .settings_bus_clk, .settings_bus_strobe,
	.settings_bus_write_enable, .settings_bus_addr, .settings_bus_ack, .lock_indicator,
	.phase_source_status, .standby_request, .pll_reset, .full_reset_with_input_divider,
	.out_b_divider_reset, .out_c_divider_reset, .primary_out_enable, .primary_out_clk,
	.secondary_out_clk_b, .secondary_out_clk_c);

// ---- bench/pllctl_user.sv ----
`timescale 1ns/1ps
module pllctl_user (
	input  wire logic       clock,
	input  wire logic       settings_bus_ack,
	output logic            settings_bus_clk = 1'b0,
	output logic            settings_bus_reset = 1'b0,
	output logic            settings_bus_strobe = 1'b0,
	output logic            settings_bus_write_enable = 1'b0,
	output logic [4:0]      settings_bus_addr = 5'h00,
	output logic [7:0]      settings_bus_wdata = 8'h00
);
	// bus clock only runs inside a transfer or a bus reset
	task automatic tick(input int half);
		repeat (half) @(posedge clock);
		settings_bus_clk <= 1'b1;
		repeat (half) @(posedge clock);
		settings_bus_clk <= 1'b0;
	endtask
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, input int h);
		int n;
		n = 0;
		@(posedge clock);
		settings_bus_strobe <= 1'b1;
		settings_bus_write_enable <= w;
		settings_bus_addr <= a;
		settings_bus_wdata <= d;
		while (settings_bus_ack !== 1'b1 && n < 8) begin
			tick(h);
			n++;
		end
		tick(h);
		settings_bus_strobe <= 1'b0;
		// released lines carry garbage, not the old value
		settings_bus_write_enable <= ~w;
		settings_bus_addr <= ~a;
		settings_bus_wdata <= ~d;
		tick(h);
	endtask
	task automatic bus_reset();
		@(posedge clock);
		settings_bus_reset <= 1'b1;
		tick(2);
		settings_bus_reset <= 1'b0;
	endtask
endmodule

// ---- bench/pllctl_top_tb.sv ----
`timescale 1ns/1ps
module pllctl_top_tb;
	logic clock = 1'b0, rst = 1'b1, ref_clk_in_a = 1'b0, ref_clk_in_b = 1'b0, ref_select = 1'b0;
	logic feedback_clk_in = 1'b0, phase_direction = 1'b0, phase_step_toggle = 1'b0;
	logic standby_request = 1'b0, pll_reset = 1'b0, full_reset_with_input_divider = 1'b0;
	logic out_b_divider_reset = 1'b0, out_c_divider_reset = 1'b0, primary_out_enable = 1'b1;
	logic secondary_a_out_enable = 1'b1, secondary_b_out_enable = 1'b1;
	logic secondary_c_out_enable = 1'b1, settings_bus_clk, settings_bus_reset;
	logic settings_bus_strobe, settings_bus_write_enable, settings_bus_ack, ack_d = 1'b0;
	logic primary_out_clk, secondary_out_clk_a, secondary_out_clk_b, secondary_out_clk_c;
	logic lock_indicator, phase_source_status;
	logic [1:0] phase_output_select = 2'h0;
	logic [4:0] settings_bus_addr;
	logic [7:0] settings_bus_wdata, settings_bus_rdata;
	logic [7:0] shadow [32];
	logic [7:0] expq [$];
	logic [31:0] seed = 32'h0000_0001;
	logic [31:0] r;
	int mismatches = 0, n_tests = 0, cyc = 0;
	wire [3:0] oclk = {secondary_out_clk_c, secondary_out_clk_b, secondary_out_clk_a,
		primary_out_clk};
	pllctl_top DUT (.clock, .rst, .ref_clk_in_a, .ref_clk_in_b, .ref_select, .feedback_clk_in,
		.phase_output_select, .phase_direction, .phase_step_toggle, .standby_request,
		.pll_reset, .full_reset_with_input_divider, .out_b_divider_reset, .out_c_divider_reset,
		.primary_out_enable, .secondary_a_out_enable, .secondary_b_out_enable,
		.secondary_c_out_enable, .settings_bus_clk, .settings_bus_reset, .settings_bus_strobe,
		.settings_bus_write_enable, .settings_bus_addr, .settings_bus_wdata,
		.settings_bus_rdata, .settings_bus_ack, .primary_out_clk, .secondary_out_clk_a,
		.secondary_out_clk_b, .secondary_out_clk_c, .lock_indicator, .phase_source_status);
	pllctl_user U (.clock, .settings_bus_ack, .settings_bus_clk, .settings_bus_reset,
		.settings_bus_strobe, .settings_bus_write_enable, .settings_bus_addr,
		.settings_bus_wdata);
	always #50 clock = ~clock;
	always @(posedge clock) ref_clk_in_a <= ~ref_clk_in_a;
	always @(posedge clock) feedback_clk_in <= primary_out_clk;
	always begin
		repeat (3) @(posedge clock);
		ref_clk_in_b <= ~ref_clk_in_b;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic results();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		expq.push_back((a > 5'h0A) ? 8'h00 : shadow[a]);
		if (w && a < 5'h0A) shadow[a] = d;
		r = rnd();
		U.xfer(w, a, d, 1 + 2 * int'(r[0]));
	endtask
	task automatic lock_is(input logic v, input int wait_max);
		int n;
		n = 0;
		while (lock_indicator !== v && n < wait_max) begin
			@(posedge clock);
			n++;
		end
		chk({7'h00, lock_indicator}, {7'h00, v}, "lock");
	endtask
	// ********
	// result watcher and run limit
	// ********
	always @(negedge clock) begin
		ack_d <= settings_bus_ack;
		if (settings_bus_ack === 1'b1 && ack_d === 1'b0) begin
			chk(settings_bus_rdata, expq.pop_front(), "rdata");
		end
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		for (int i = 0; i < 32; i++) shadow[i] = (i < 4) ? 8'h03 : {7'h00, i == 4};
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 32; i++) if (i != 10) bus(1'b0, i[4:0], 8'h00);
		for (int i = 0; i < 32; i++) begin
			r = rnd();
			if (i != 10) bus(1'b1, i[4:0], {4'h0, r[3:0] & {4{i != 9}}});
		end
		for (int i = 0; i < 32; i++) if (i != 10) bus(1'b0, i[4:0], 8'h00);
		lock_is(1'b1, 400);
		bus(1'b1, 5'h00, 8'h02);
		lock_is(1'b0, 1);
		lock_is(1'b1, 400);
		for (int i = 0; i < 12; i++) begin
			@(posedge clock);
			r = rnd();
			phase_output_select <= 2'(1 + i % 3);
			phase_direction <= r[0];
			{secondary_c_out_enable, secondary_b_out_enable, secondary_a_out_enable,
				primary_out_enable} <= r[4:1];
			@(posedge clock);
			phase_step_toggle <= ~phase_step_toggle;
		end
		@(posedge clock);
		lock_is(1'b1, 3);
		phase_output_select <= 2'h0;
		@(posedge clock);
		phase_step_toggle <= ~phase_step_toggle;
		repeat (3) @(posedge clock);
		lock_is(1'b0, 1);
		lock_is(1'b1, 400);
		ref_select <= 1'b1;
		repeat (3) @(posedge clock);
		lock_is(1'b0, 1);
		bus(1'b1, 5'h09, 8'h01);
		chk({7'h00, phase_source_status}, 8'h01, "source");
		lock_is(1'b1, 400);
		phase_step_toggle <= ~phase_step_toggle;
		repeat (3) @(posedge clock);
		lock_is(1'b1, 1);
		U.bus_reset();
		bus(1'b0, 5'h09, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lock_is(1'b1, 400);
			{out_c_divider_reset, out_b_divider_reset, full_reset_with_input_divider,
				pll_reset} <= 4'h1 << i;
			repeat (4) @(posedge clock);
			lock_is(i > 1, 1);
			chk({4'h0, oclk & {i == 3, i == 2, 2'h0}}, 8'h00, "div rst");
			{out_c_divider_reset, out_b_divider_reset, full_reset_with_input_divider,
				pll_reset} <= 4'h0;
			@(posedge clock);
		end
		standby_request <= 1'b1;
		shadow[10] = 8'h02;
		bus(1'b1, 5'h0A, 8'hFF);
		bus(1'b0, 5'h0A, 8'h00);
		chk({3'h0, lock_indicator, oclk}, 8'h00, "standby");
		standby_request <= 1'b0;
		lock_is(1'b1, 400);
		results();
	end
endmodule
